// file: bench/mcu_move_return_rotate_exec_tb_top.sv
// Self-checking bench for the move/return/rotate executor
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("FAIL %s exp %h got %h", nm, ex, got); end end
module mcu_move_return_rotate_exec_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic instr_valid = 1'h0;
    logic dest_sel = 1'h0;
    logic call_push = 1'h0;
    logic irq_taken = 1'h0;
    logic [2:0] opcode = 3'h0;
    logic [6:0] file_addr = 7'h00;
    logic [7:0] imm_val = 8'h00;
    logic [7:0] file_rdata = 8'h00;
    logic [10:0] call_target = 11'h000;
    logic busy, zero_flag, carry_flag, global_interrupt_enable, file_we;
    logic [7:0] accumulator, file_wdata;
    logic [10:0] pc;
    logic [3:0] stack_level;
    logic [6:0] file_waddr;
    logic [10:0] exp_pc = 11'h000;
    logic [10:0] exp_ret = 11'h000;
    int n_mismatch = 0;
    int comparisons = 0;
    mre_exec uut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .opcode(opcode), .file_addr(file_addr), .dest_sel(dest_sel),
        .imm_val(imm_val), .file_rdata(file_rdata), .call_push(call_push),
        .call_target(call_target), .irq_taken(irq_taken), .busy(busy),
        .accumulator(accumulator), .pc(pc), .stack_level(stack_level),
        .zero_flag(zero_flag), .carry_flag(carry_flag),
        .global_interrupt_enable(global_interrupt_enable),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));
    always #50 clk = ~clk;
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic exec(input logic [2:0] op, input logic [6:0] a,
            input logic d, input logic [7:0] im, input logic [7:0] rd);
        @(posedge clk);
        opcode <= op;
        file_addr <= a;
        dest_sel <= d;
        imm_val <= im;
        file_rdata <= rd;
        instr_valid <= 1'h1;
        @(posedge clk);
        instr_valid <= 1'h0;
        #1;
        if (op == mre_pkg::OP_INT_RETURN || op == mre_pkg::OP_RET_IMM) begin
            exp_pc = exp_ret;
        end else begin
            exp_pc++;
        end
    endtask
    // Test hook: push return address and jump
    task automatic do_call(input logic [10:0] t);
        @(posedge clk);
        call_push <= 1'h1;
        call_target <= t;
        @(posedge clk);
        call_push <= 1'h0;
        #1;
        exp_ret = exp_pc + 11'h001;
        exp_pc = t;
        `CHK("call pc", t, pc)
        `CHK("call lvl", 4'h1, stack_level)
    endtask
    task automatic t_moves();
        exec(mre_pkg::OP_IMM_TO_ACC, 7'h00, 1'h0, 8'h55, 8'h00);
        `CHK("acc", 8'h55, accumulator)
        `CHK("zero", 1'h0, zero_flag)
        exec(mre_pkg::OP_ACC_TO_FILE, 7'h7f, 1'h0, 8'h00, 8'h00);
        `CHK("we", 1'h1, file_we)
        `CHK("waddr", 7'h7f, file_waddr)
        `CHK("wdata", 8'h55, file_wdata)
        tick();
        `CHK("we off", 1'h0, file_we)
        exec(mre_pkg::OP_NOP, 7'h00, 1'h0, 8'h00, 8'h00);
        `CHK("nop pc", exp_pc, pc)
        `CHK("nop acc", 8'h55, accumulator)
    endtask
    task automatic t_move_zero();
        exec(mre_pkg::OP_FILE_MOVE, 7'h10, 1'h0, 8'h00, 8'h00);
        `CHK("mv acc", 8'h00, accumulator)
        `CHK("mv zero", 1'h1, zero_flag)
        `CHK("mv pc", exp_pc, pc)
        // Zero flag is 1 and the operand nonzero, so a flag update shows
        exec(mre_pkg::OP_IMM_TO_ACC, 7'h00, 1'h0, 8'h3c, 8'h00);
        `CHK("imm acc", 8'h3c, accumulator)
        `CHK("imm zero", 1'h1, zero_flag)
    endtask
    task automatic t_rotate();
        // Zero flag is 1 here, so a stray flag update shows
        exec(mre_pkg::OP_ROT_LEFT, 7'h21, 1'h1, 8'h00, 8'ha5);
        `CHK("rl wdata", 8'h4a, file_wdata)
        `CHK("rl waddr", 7'h21, file_waddr)
        `CHK("rl c", 1'h1, carry_flag)
        `CHK("rl zero", 1'h1, zero_flag)
        exec(mre_pkg::OP_ROT_LEFT, 7'h21, 1'h0, 8'h00, 8'h01);
        `CHK("rl acc", 8'h03, accumulator)
        `CHK("rl c0", 1'h0, carry_flag)
        `CHK("rl we", 1'h0, file_we)
    endtask
    task automatic t_move_back();
        exec(mre_pkg::OP_FILE_MOVE, 7'h10, 1'h1, 8'h00, 8'ha5);
        `CHK("mvb wdata", 8'ha5, file_wdata)
        `CHK("mvb acc", 8'h03, accumulator)
        `CHK("mvb zero", 1'h0, zero_flag)
    endtask
    task automatic t_ret_imm();
        do_call(11'h123);
        exec(mre_pkg::OP_RET_IMM, 7'h00, 1'h0, 8'haa, 8'h00);
        `CHK("ri acc", 8'haa, accumulator)
        `CHK("ri pc", exp_pc, pc)
        `CHK("ri busy", 1'h1, busy)
        `CHK("ri lvl", 4'h1, stack_level)
        tick();
        `CHK("ri lvl2", 4'h0, stack_level)
        `CHK("ri busy2", 1'h0, busy)
    endtask
    task automatic t_int_ret();
        do_call(11'h456);
        exec(mre_pkg::OP_INT_RETURN, 7'h00, 1'h0, 8'h00, 8'h00);
        `CHK("ie pc", exp_pc, pc)
        `CHK("ie gie", 1'h1, global_interrupt_enable)
        `CHK("ie busy", 1'h1, busy)
        tick();
        `CHK("ie lvl", 4'h0, stack_level)
        `CHK("ie acc", 8'haa, accumulator)
        @(posedge clk);
        irq_taken <= 1'h1;
        @(posedge clk);
        irq_taken <= 1'h0;
        #1;
        `CHK("irq gie", 1'h0, global_interrupt_enable)
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        #1;
        `CHK("rst acc", 8'h00, accumulator)
        `CHK("rst pc", 11'h000, pc)
        `CHK("rst gie", 1'h0, global_interrupt_enable)
        t_moves();
        t_move_zero();
        t_rotate();
        t_move_back();
        t_ret_imm();
        t_int_ret();
        end_sim();
    end
    // Whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule

// file: logic/mre_exec.sv
// Executor for moves, immediate loads, returns and left rotate
`timescale 1ns/100ps
module mre_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [2:0] opcode,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] imm_val,
    input wire logic [7:0] file_rdata,
    input wire logic call_push,
    input wire logic [10:0] call_target,
    input wire logic irq_taken,
    output logic busy,
    output logic [7:0] accumulator,
    output logic [10:0] pc,
    output logic [3:0] stack_level,
    output logic zero_flag,
    output logic carry_flag,
    output logic global_interrupt_enable,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata
);
    mre_pkg::mre_state_t state_ff;
    logic [10:0] stack_mem [mre_pkg::STK_DEPTH];
    logic go;
    logic [7:0] rot_val;
    logic [2:0] top_idx;
    logic [2:0] push_idx;

    assign go = instr_valid && state_ff == mre_pkg::MRE_FETCH;
    assign rot_val = {file_rdata[6:0], carry_flag};
    assign top_idx = 3'(stack_level - mre_pkg::LVL_ONE);
    assign push_idx = stack_level[2:0];

    // Returns hold one extra cycle in the second state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= mre_pkg::MRE_FETCH;
        end else if (go && (opcode == mre_pkg::OP_INT_RETURN ||
                            opcode == mre_pkg::OP_RET_IMM)) begin
            state_ff <= mre_pkg::MRE_RET2;
        end else begin
            state_ff <= mre_pkg::MRE_FETCH;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= go && (opcode == mre_pkg::OP_INT_RETURN ||
                           opcode == mre_pkg::OP_RET_IMM);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            accumulator <= mre_pkg::ACC_RST;
        end else if (go) begin
            case (opcode)
                mre_pkg::OP_IMM_TO_ACC: accumulator <= imm_val;
                mre_pkg::OP_RET_IMM: accumulator <= imm_val;
                mre_pkg::OP_FILE_MOVE: begin
                    if (!dest_sel) begin
                        accumulator <= file_rdata;
                    end
                end
                mre_pkg::OP_ROT_LEFT: begin
                    if (!dest_sel) begin
                        accumulator <= rot_val;
                    end
                end
                default: accumulator <= accumulator;
            endcase
        end
    end

    // File write port; one cycle per write
    always_ff @(posedge clk) begin
        if (rst) begin
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else begin
            file_we <= 1'b0;
            file_waddr <= file_addr;
            file_wdata <= accumulator;
            if (go) begin
                case (opcode)
                    mre_pkg::OP_ACC_TO_FILE: file_we <= 1'b1;
                    mre_pkg::OP_FILE_MOVE: begin
                        file_we <= dest_sel;
                        file_wdata <= file_rdata;
                    end
                    mre_pkg::OP_ROT_LEFT: begin
                        file_we <= dest_sel;
                        file_wdata <= rot_val;
                    end
                    default: file_we <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            zero_flag <= 1'b0;
        end else if (go && opcode == mre_pkg::OP_FILE_MOVE) begin
            zero_flag <= (file_rdata == 8'h00);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            carry_flag <= 1'b0;
        end else if (go && opcode == mre_pkg::OP_ROT_LEFT) begin
            carry_flag <= file_rdata[7];
        end
    end

    // Interrupt entry clears the enable; interrupt return sets it
    always_ff @(posedge clk) begin
        if (rst) begin
            global_interrupt_enable <= 1'b0;
        end else if (go && opcode == mre_pkg::OP_INT_RETURN) begin
            global_interrupt_enable <= 1'b1;
        end else if (irq_taken) begin
            global_interrupt_enable <= 1'b0;
        end
    end

    // PC loads from stack top in the first return cycle, pop in the second
    always_ff @(posedge clk) begin
        if (rst) begin
            pc <= mre_pkg::PC_RST;
        end else if (call_push && state_ff == mre_pkg::MRE_FETCH) begin
            pc <= call_target;
        end else if (go) begin
            if (opcode == mre_pkg::OP_INT_RETURN ||
                opcode == mre_pkg::OP_RET_IMM) begin
                pc <= stack_mem[top_idx];
            end else begin
                pc <= pc + mre_pkg::PC_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stack_level <= mre_pkg::LVL_RST;
        end else if (state_ff == mre_pkg::MRE_RET2) begin
            stack_level <= stack_level - mre_pkg::LVL_ONE;
        end else if (call_push && stack_level < 4'(mre_pkg::STK_DEPTH)) begin
            stack_level <= stack_level + mre_pkg::LVL_ONE;
        end
    end

    // Stack store; no reset so it maps to plain memory
    always_ff @(posedge clk) begin
        if (call_push && state_ff == mre_pkg::MRE_FETCH) begin
            stack_mem[push_idx] <= pc + mre_pkg::PC_ONE;
        end
    end

    sequence s_ret_tail;
        busy ##1 !busy;
    endsequence
    property p_ret_two;
        @(posedge clk) disable iff (rst)
        go && (opcode == mre_pkg::OP_RET_IMM ||
               opcode == mre_pkg::OP_INT_RETURN) |-> ##1 s_ret_tail;
    endproperty
    ret_two_cyc_a: assert property (p_ret_two)
        else $error("return not two cycles");
    ret_flags_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_RET_IMM |=>
        $stable(zero_flag) && $stable(carry_flag))
        else $error("return with value changed a flag");
    pop_level_a: assert property (@(posedge clk) disable iff (rst)
        busy |=> stack_level == $past(stack_level) - 4'h1)
        else $error("return did not pop");
    gie_set_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_INT_RETURN |=> global_interrupt_enable)
        else $error("interrupt enable not set");
    rot_carry_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_ROT_LEFT |=>
        carry_flag == $past(file_rdata[7]))
        else $error("rotate carry wrong");
    zero_mv_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_FILE_MOVE |=>
        zero_flag == ($past(file_rdata) == 8'h00))
        else $error("zero flag wrong");
    imm_load_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_IMM_TO_ACC |=>
        accumulator == $past(imm_val) && $stable(zero_flag))
        else $error("immediate load wrong");
    nop_pc_a: assert property (@(posedge clk) disable iff (rst)
        go && !call_push && opcode == mre_pkg::OP_NOP |=>
        pc == $past(pc) + 11'h001 && $stable(accumulator))
        else $error("nop wrong");
    acc_write_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_ACC_TO_FILE |=>
        file_we && file_wdata == $past(accumulator))
        else $error("acc to file write wrong");
    move_back_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_FILE_MOVE && dest_sel |=>
        file_we && file_wdata == $past(file_rdata))
        else $error("file move write back wrong");
    rot_dest_a: assert property (@(posedge clk) disable iff (rst)
        go && opcode == mre_pkg::OP_ROT_LEFT && !dest_sel |=>
        accumulator == {$past(file_rdata[6:0]), $past(carry_flag)} && !file_we)
        else $error("rotate to acc wrong");
endmodule

// file: logic/mre_pkg.sv
// Package of constants and types for the move/return/rotate executor
package mre_pkg;
    localparam int ACC_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 11;
    localparam int STK_DEPTH = 8;
    localparam int STK_LVL_W = 4;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [3:0] LVL_RST = 4'h0;
    localparam logic [3:0] LVL_ONE = 4'h1;
    localparam logic [10:0] PC_ONE = 11'h001;
    localparam int ZERO_BIT = 0;
    localparam int CARRY_BIT = 1;
    localparam logic [2:0] OP_NOP = 3'h0;
    localparam logic [2:0] OP_ACC_TO_FILE = 3'h1;
    localparam logic [2:0] OP_IMM_TO_ACC = 3'h2;
    localparam logic [2:0] OP_FILE_MOVE = 3'h3;
    localparam logic [2:0] OP_INT_RETURN = 3'h4;
    localparam logic [2:0] OP_RET_IMM = 3'h5;
    localparam logic [2:0] OP_ROT_LEFT = 3'h6;
    typedef enum logic [1:0] {MRE_FETCH, MRE_RET2} mre_state_t;
endpackage
